// ==== power_control_defines.svh ====
// Register offsets, field positions and reset values of the power control registers
`ifndef POWER_CONTROL_DEFINES_SVH
`define POWER_CONTROL_DEFINES_SVH

`define ADDR_W 8
`define OFF_SEQ_STATUS 8'h24
`define OFF_CONV_CTRL 8'h2c
`define OFF_SUPPLY_STATUS 8'h30
`define OFF_CORE_LEVEL 8'h34
`define OFF_PLL_LEVEL 8'h40

`define SEQ_PREV_IO_BIT 29
`define SEQ_PREV_PLL_BIT 28
`define SEQ_PREV_ANALOG_BIT 25
`define SEQ_PREV_CORE_BIT 24
`define SEQ_STATE_HI 18
`define SEQ_STATE_LO 16
`define SEQ_TILE_CLK_OFF_BIT 14
`define SEQ_ANALOG_MOD_BIT 9
`define SEQ_CORE_MOD_BIT 8
`define SEQ_EN_IO_BIT 5
`define SEQ_EN_PLL_BIT 4
`define SEQ_EN_ANALOG_BIT 1
`define SEQ_EN_CORE_BIT 0
`define SEQ_PREV_ANALOG_RST 1'h1

`define CTRL_PG_HI 25
`define CTRL_PG_LO 24
`define CTRL_ERR_CLR_BIT 16
`define CTRL_ANALOG_ILIM_HI 14
`define CTRL_ANALOG_ILIM_LO 13
`define CTRL_ANALOG_CLK_HI 9
`define CTRL_ANALOG_CLK_LO 8
`define CTRL_CORE_ILIM_HI 6
`define CTRL_CORE_ILIM_LO 5
`define CTRL_CORE_CLK_HI 1
`define CTRL_CORE_CLK_LO 0
`define CTRL_PG_RST 2'h2
`define CTRL_ILIM_RST 2'h0
`define CTRL_CLK_RST 2'h1

`define SUP_OSC_STABLE_BIT 24
`define SUP_PLL_GOOD_BIT 19
`define SUP_CORE_GOOD_BIT 16
`define SUP_ANALOG_ILIM_BIT 9
`define SUP_CORE_ILIM_BIT 8
`define SUP_ANALOG_SOFT_BIT 1
`define SUP_CORE_SOFT_BIT 0

`define CORE_LEVEL_W 7
`define PLL_LEVEL_W 3

`endif

// ==== power_control_pkg.sv ====
// Types shared by the power control register bank
package power_control_pkg;
    typedef enum logic [2:0] {
        st_reset,
        st_asleep,
        st_waking1,
        st_waking2,
        st_awake_wait,
        st_awake,
        st_sleeping1,
        st_sleeping2
    } seq_state_t;
endpackage : power_control_pkg

// ==== power_status_if.sv ====
// Captured sequencer and supply status passed to the register bank
`timescale 1ns/100ps
`default_nettype none
interface power_status_if;
    import power_control_pkg::*;
    logic prev_io, prev_pll, prev_analog, prev_core;
    seq_state_t state;
    logic tile_clk_off, analog_mod, core_mod;
    logic en_io, en_pll, en_analog, en_core;
    logic osc_stable, pll_good, core_good;
    logic analog_ilim, core_ilim, analog_soft, core_soft;
    modport producer (output prev_io, prev_pll, prev_analog, prev_core, state,
        tile_clk_off, analog_mod, core_mod, en_io, en_pll, en_analog, en_core,
        osc_stable, pll_good, core_good, analog_ilim, core_ilim, analog_soft, core_soft);
    modport consumer (input prev_io, prev_pll, prev_analog, prev_core, state,
        tile_clk_off, analog_mod, core_mod, en_io, en_pll, en_analog, en_core,
        osc_stable, pll_good, core_good, analog_ilim, core_ilim, analog_soft, core_soft);
endinterface : power_status_if
`default_nettype wire

// ==== status_capture.sv ====
// Registers the sequencer and supply status seen by software
`timescale 1ns/100ps
`default_nettype none
`include "power_control_defines.svh"
module status_capture (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire power_control_pkg::seq_state_t seq_state,
    input wire logic [3:0] prev_enables,
    input wire logic [2:0] active_mode,
    input wire logic [3:0] active_enables,
    input wire logic [6:0] supply_flags,
    power_status_if.producer st
);
    import power_control_pkg::*;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st.prev_io <= 1'h0;
            st.prev_pll <= 1'h0;
            st.prev_analog <= `SEQ_PREV_ANALOG_RST;
            st.prev_core <= 1'h0;
        end else begin
            {st.prev_io, st.prev_pll, st.prev_analog, st.prev_core} <= prev_enables; // RQ1
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st.state <= st_reset;
            {st.tile_clk_off, st.analog_mod, st.core_mod} <= 3'h0;
            {st.en_io, st.en_pll, st.en_analog, st.en_core} <= 4'h0;
        end else begin
            st.state <= seq_state; // RQ2
            {st.tile_clk_off, st.analog_mod, st.core_mod} <= active_mode; // RQ3
            {st.en_io, st.en_pll, st.en_analog, st.en_core} <= active_enables; // RQ3
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {st.osc_stable, st.pll_good, st.core_good} <= 3'h0;
            {st.analog_ilim, st.core_ilim, st.analog_soft, st.core_soft} <= 4'h0;
        end else begin
            {st.osc_stable, st.pll_good, st.core_good} <= supply_flags[6:4]; // RQ10
            {st.analog_ilim, st.core_ilim} <= supply_flags[3:2]; // RQ11
            {st.analog_soft, st.core_soft} <= supply_flags[1:0]; // RQ12
        end
    end

    property p_prev_follow;
        @(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> {st.prev_io, st.prev_pll, st.prev_analog, st.prev_core} == $past(prev_enables);
    endproperty
    a_prev_follow: assert property (p_prev_follow) else $error("previous enables lag"); // RQ1

    property p_supply_follow;
        @(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> {st.analog_ilim, st.core_ilim, st.analog_soft, st.core_soft}
            == $past(supply_flags[3:0]);
    endproperty
    a_supply_follow: assert property (p_supply_follow) else $error("supply flags lag"); // RQ11
endmodule : status_capture
`default_nettype wire

// ==== rail_level_regs.sv ====
// Core rail and PLL regulator level registers loaded from the straps
`timescale 1ns/100ps
`default_nettype none
`include "power_control_defines.svh"
module rail_level_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wr_core,
    input wire logic wr_pll,
    input wire logic [31:0] wdata,
    input wire logic [`CORE_LEVEL_W-1:0] strap_core,
    input wire logic [`PLL_LEVEL_W-1:0] strap_pll,
    output logic [`CORE_LEVEL_W-1:0] core_level_reg,
    output logic [`PLL_LEVEL_W-1:0] pll_level_reg,
    output logic loaded_reg
);
    // Straps are caught on the first edge after release, never under the reset itself
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loaded_reg <= 1'h0;
        end else begin
            loaded_reg <= 1'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_level_reg <= '0;
        end else if (!loaded_reg) begin
            core_level_reg <= strap_core; // RQ15
        end else if (wr_core) begin
            core_level_reg <= wdata[`CORE_LEVEL_W-1:0]; // RQ13
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_level_reg <= '0;
        end else if (!loaded_reg) begin
            pll_level_reg <= strap_pll; // RQ15
        end else if (wr_pll) begin
            pll_level_reg <= wdata[`PLL_LEVEL_W-1:0]; // RQ16
        end
    end

    property p_strap_load;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(loaded_reg) |-> core_level_reg == $past(strap_core)
            && pll_level_reg == $past(strap_pll);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded"); // RQ15

    property p_core_write;
        @(posedge clk_sys) disable iff (!resetn)
        loaded_reg && wr_core |=> core_level_reg == $past(wdata[`CORE_LEVEL_W-1:0]);
    endproperty
    a_core_write: assert property (p_core_write) else $error("core level not written"); // RQ13
endmodule : rail_level_regs
`default_nettype wire

// ==== power_control_status_regs.sv ====
// Software register bank of the power control block
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "power_control_defines.svh"

// Behaviour
// RQ1: Previous-state supply enables at bits 29,28,25,24
// RQ2: Current sequencer state readable at bits 18:16
// RQ3: Active clock, modulation and enable settings mirrored
// RQ4: Power-good threshold select, resets to two
// RQ5: Error clear bit holds until written zero
// RQ6: Analog converter current limit, resets zero
// RQ7: Analog converter clock select, resets one
// RQ8: Core converter current limit, resets zero
// RQ9: Core converter clock select, resets one
// RQ10: Oscillator, PLL rail, core rail good flags
// RQ11: Current limiting flags at bits 9, 8
// RQ12: Soft-start flags at bits 1, 0
// RQ13: Core rail level, seven bits, 10 mV steps
// RQ14: Software steps core level slowly
// RQ15: Level reset values come from strap pins; levels reset to zero, straps load on the first edge after release
// RQ16: PLL regulator level, three bits, 100 mV
// RQ17: Software raises PLL level one step
// RQ18: State codes zero to seven in order
module power_control_status_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire power_control_pkg::seq_state_t seq_state,
    input wire logic [3:0] prev_enables,
    input wire logic [2:0] active_mode,
    input wire logic [3:0] active_enables,
    input wire logic [6:0] supply_flags,
    input wire logic [`CORE_LEVEL_W-1:0] strap_core_level,
    input wire logic [`PLL_LEVEL_W-1:0] strap_pll_level,
    output logic [1:0] pg_threshold,
    output logic err_clear,
    output logic [1:0] analog_ilimit,
    output logic [1:0] analog_clk_sel,
    output logic [1:0] core_ilimit,
    output logic [1:0] core_clk_sel,
    output logic [`CORE_LEVEL_W-1:0] core_rail_level,
    output logic [`PLL_LEVEL_W-1:0] pll_regulator_level
);
    import power_control_pkg::*;

    // ****************************************
    // Decode
    // ****************************************
    function automatic logic hit(input logic [`ADDR_W-1:0] addr,
                                 input logic [`ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction : hit

    logic wr_ctrl;
    logic wr_core;
    logic wr_pll;
    logic mapped;
    logic levels_loaded;
    logic [31:0] rd_word;
    logic [31:0] rdata_reg;
    logic [1:0] pg_reg;
    logic err_clr_reg;
    logic [1:0] analog_ilim_reg;
    logic [1:0] analog_clk_reg;
    logic [1:0] core_ilim_reg;
    logic [1:0] core_clk_reg;

    assign wr_ctrl = reg_wr && hit(reg_addr, `OFF_CONV_CTRL);
    assign wr_core = reg_wr && hit(reg_addr, `OFF_CORE_LEVEL);
    assign wr_pll = reg_wr && hit(reg_addr, `OFF_PLL_LEVEL);
    assign mapped = hit(reg_addr, `OFF_SEQ_STATUS) || hit(reg_addr, `OFF_CONV_CTRL)
        || hit(reg_addr, `OFF_SUPPLY_STATUS) || hit(reg_addr, `OFF_CORE_LEVEL)
        || hit(reg_addr, `OFF_PLL_LEVEL);

    // ****************************************
    // Status capture and level registers
    // ****************************************
    power_status_if st ();

    status_capture u_capture (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .seq_state(seq_state),
        .prev_enables(prev_enables),
        .active_mode(active_mode),
        .active_enables(active_enables),
        .supply_flags(supply_flags),
        .st(st.producer)
    );

    // Level writes before the straps are caught are dropped; the strap load wins
    rail_level_regs u_levels (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_core(wr_core),
        .wr_pll(wr_pll),
        .wdata(reg_wdata),
        .strap_core(strap_core_level),
        .strap_pll(strap_pll_level),
        .core_level_reg(core_rail_level),
        .pll_level_reg(pll_regulator_level),
        .loaded_reg(levels_loaded)
    );

    // ****************************************
    // Converter control
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pg_reg <= `CTRL_PG_RST;
        end else if (wr_ctrl) begin
            pg_reg <= reg_wdata[`CTRL_PG_HI:`CTRL_PG_LO]; // RQ4
        end
    end

    // Held level, so the error flags stay cleared until software lets them go
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            err_clr_reg <= 1'h0;
        end else if (wr_ctrl) begin
            err_clr_reg <= reg_wdata[`CTRL_ERR_CLR_BIT]; // RQ5
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            analog_ilim_reg <= `CTRL_ILIM_RST;
            analog_clk_reg <= `CTRL_CLK_RST;
        end else if (wr_ctrl) begin
            analog_ilim_reg <= reg_wdata[`CTRL_ANALOG_ILIM_HI:`CTRL_ANALOG_ILIM_LO]; // RQ6
            analog_clk_reg <= reg_wdata[`CTRL_ANALOG_CLK_HI:`CTRL_ANALOG_CLK_LO]; // RQ7
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_ilim_reg <= `CTRL_ILIM_RST;
            core_clk_reg <= `CTRL_CLK_RST;
        end else if (wr_ctrl) begin
            core_ilim_reg <= reg_wdata[`CTRL_CORE_ILIM_HI:`CTRL_CORE_ILIM_LO]; // RQ8
            core_clk_reg <= reg_wdata[`CTRL_CORE_CLK_HI:`CTRL_CORE_CLK_LO]; // RQ9
        end
    end

    assign pg_threshold = pg_reg;
    assign err_clear = err_clr_reg;
    assign analog_ilimit = analog_ilim_reg;
    assign analog_clk_sel = analog_clk_reg;
    assign core_ilimit = core_ilim_reg;
    assign core_clk_sel = core_clk_reg;

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rd_word = 32'h0;
        case (reg_addr)
            `OFF_SEQ_STATUS: begin
                rd_word[`SEQ_PREV_IO_BIT] = st.prev_io; // RQ1
                rd_word[`SEQ_PREV_PLL_BIT] = st.prev_pll; // RQ1
                rd_word[`SEQ_PREV_ANALOG_BIT] = st.prev_analog; // RQ1
                rd_word[`SEQ_PREV_CORE_BIT] = st.prev_core; // RQ1
                rd_word[`SEQ_STATE_HI:`SEQ_STATE_LO] = st.state; // RQ2 RQ18
                rd_word[`SEQ_TILE_CLK_OFF_BIT] = st.tile_clk_off; // RQ3
                rd_word[`SEQ_ANALOG_MOD_BIT] = st.analog_mod; // RQ3
                rd_word[`SEQ_CORE_MOD_BIT] = st.core_mod; // RQ3
                rd_word[`SEQ_EN_IO_BIT] = st.en_io; // RQ3
                rd_word[`SEQ_EN_PLL_BIT] = st.en_pll; // RQ3
                rd_word[`SEQ_EN_ANALOG_BIT] = st.en_analog; // RQ3
                rd_word[`SEQ_EN_CORE_BIT] = st.en_core; // RQ3
            end
            `OFF_CONV_CTRL: begin
                rd_word[`CTRL_PG_HI:`CTRL_PG_LO] = pg_reg;
                rd_word[`CTRL_ERR_CLR_BIT] = err_clr_reg;
                rd_word[`CTRL_ANALOG_ILIM_HI:`CTRL_ANALOG_ILIM_LO] = analog_ilim_reg;
                rd_word[`CTRL_ANALOG_CLK_HI:`CTRL_ANALOG_CLK_LO] = analog_clk_reg;
                rd_word[`CTRL_CORE_ILIM_HI:`CTRL_CORE_ILIM_LO] = core_ilim_reg;
                rd_word[`CTRL_CORE_CLK_HI:`CTRL_CORE_CLK_LO] = core_clk_reg;
            end
            `OFF_SUPPLY_STATUS: begin
                rd_word[`SUP_OSC_STABLE_BIT] = st.osc_stable; // RQ10
                rd_word[`SUP_PLL_GOOD_BIT] = st.pll_good; // RQ10
                rd_word[`SUP_CORE_GOOD_BIT] = st.core_good; // RQ10
                rd_word[`SUP_ANALOG_ILIM_BIT] = st.analog_ilim; // RQ11
                rd_word[`SUP_CORE_ILIM_BIT] = st.core_ilim; // RQ11
                rd_word[`SUP_ANALOG_SOFT_BIT] = st.analog_soft; // RQ12
                rd_word[`SUP_CORE_SOFT_BIT] = st.core_soft; // RQ12
            end
            `OFF_CORE_LEVEL: begin
                rd_word[`CORE_LEVEL_W-1:0] = core_rail_level; // RQ13
            end
            `OFF_PLL_LEVEL: begin
                rd_word[`PLL_LEVEL_W-1:0] = pll_regulator_level; // RQ16
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // Data stand for one cycle only; zero otherwise so stale words never leak
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0;
        end else if (reg_rd) begin
            rdata_reg <= rd_word;
        end else begin
            rdata_reg <= 32'h0;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    property p_unmapped_zero;
        reg_rd && !mapped |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_state_read;
        reg_rd && hit(reg_addr, `OFF_SEQ_STATUS)
            |=> reg_rdata[`SEQ_STATE_HI:`SEQ_STATE_LO] == $past(st.state);
    endproperty
    a_state_read: assert property (p_state_read) else $error("state field wrong"); // RQ2

    property p_state_lag;
        1'b1 |=> st.state == $past(seq_state);
    endproperty
    a_state_lag: assert property (p_state_lag) else $error("state capture lag"); // RQ18

    property p_mirror_read;
        reg_rd && hit(reg_addr, `OFF_SEQ_STATUS)
            |=> reg_rdata[`SEQ_EN_CORE_BIT] == $past(st.en_core)
            && reg_rdata[`SEQ_TILE_CLK_OFF_BIT] == $past(st.tile_clk_off);
    endproperty
    a_mirror_read: assert property (p_mirror_read) else $error("mirror bits wrong"); // RQ3

    property p_pg_write;
        wr_ctrl |=> pg_threshold == $past(reg_wdata[`CTRL_PG_HI:`CTRL_PG_LO]);
    endproperty
    a_pg_write: assert property (p_pg_write) else $error("threshold not written"); // RQ4

    property p_err_hold;
        wr_ctrl && reg_wdata[`CTRL_ERR_CLR_BIT] ##1 !wr_ctrl [*3] |-> err_clear;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error clear not held"); // RQ5

    property p_analog_fields;
        wr_ctrl |=> analog_ilimit == $past(reg_wdata[14:13])
            && analog_clk_sel == $past(reg_wdata[9:8]);
    endproperty
    a_analog_fields: assert property (p_analog_fields) else $error("analog fields wrong"); // RQ6

    property p_analog_clk_stable;
        !wr_ctrl |=> $stable(analog_clk_sel);
    endproperty
    a_analog_clk_stable: assert property (p_analog_clk_stable) else $error("clock moved"); // RQ7

    property p_core_ilim;
        wr_ctrl |=> core_ilimit == $past(reg_wdata[6:5]);
    endproperty
    a_core_ilim: assert property (p_core_ilim) else $error("core limit wrong"); // RQ8

    property p_core_clk;
        wr_ctrl |=> core_clk_sel == $past(reg_wdata[1:0]);
    endproperty
    a_core_clk: assert property (p_core_clk) else $error("core clock wrong"); // RQ9

    property p_good_read;
        reg_rd && hit(reg_addr, `OFF_SUPPLY_STATUS)
            |=> reg_rdata[`SUP_CORE_GOOD_BIT] == $past(st.core_good)
            && reg_rdata[`SUP_OSC_STABLE_BIT] == $past(st.osc_stable);
    endproperty
    a_good_read: assert property (p_good_read) else $error("good flags wrong"); // RQ10

    property p_soft_read;
        reg_rd && hit(reg_addr, `OFF_SUPPLY_STATUS)
            |=> reg_rdata[1:0] == $past({st.analog_soft, st.core_soft});
    endproperty
    a_soft_read: assert property (p_soft_read) else $error("soft-start flags wrong"); // RQ12

    property p_pll_read;
        reg_rd && hit(reg_addr, `OFF_PLL_LEVEL)
            |=> reg_rdata == {29'h0, $past(pll_regulator_level)};
    endproperty
    a_pll_read: assert property (p_pll_read) else $error("pll level read wrong"); // RQ16

    property p_prev_read;
        reg_rd && hit(reg_addr, `OFF_SEQ_STATUS)
            |=> reg_rdata[`SEQ_PREV_IO_BIT] == $past(st.prev_io)
            && reg_rdata[`SEQ_PREV_PLL_BIT] == $past(st.prev_pll)
            && reg_rdata[`SEQ_PREV_ANALOG_BIT] == $past(st.prev_analog)
            && reg_rdata[`SEQ_PREV_CORE_BIT] == $past(st.prev_core);
    endproperty
    a_prev_read: assert property (p_prev_read) else $error("previous enables wrong"); // RQ1

    property p_err_write;
        wr_ctrl |=> err_clear == $past(reg_wdata[`CTRL_ERR_CLR_BIT]);
    endproperty
    a_err_write: assert property (p_err_write) else $error("error clear not written"); // RQ5

    property p_ilim_read;
        reg_rd && hit(reg_addr, `OFF_SUPPLY_STATUS)
            |=> reg_rdata[`SUP_ANALOG_ILIM_BIT:`SUP_CORE_ILIM_BIT]
            == $past({st.analog_ilim, st.core_ilim});
    endproperty
    a_ilim_read: assert property (p_ilim_read) else $error("limit flags wrong"); // RQ11

    property p_core_read;
        reg_rd && hit(reg_addr, `OFF_CORE_LEVEL)
            |=> reg_rdata == {25'h0, $past(core_rail_level)};
    endproperty
    a_core_read: assert property (p_core_read) else $error("core level read wrong"); // RQ13

    property p_pll_write;
        levels_loaded && wr_pll
            |=> pll_regulator_level == $past(reg_wdata[`PLL_LEVEL_W-1:0]);
    endproperty
    a_pll_write: assert property (p_pll_write) else $error("pll level not written"); // RQ16

    // Idle read data is forced to zero so a late sampler never sees a stale word
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

    c_err_clear: cover property (wr_ctrl && reg_wdata[`CTRL_ERR_CLR_BIT]);
    c_state_awake: cover property (reg_rd && hit(reg_addr, `OFF_SEQ_STATUS)
        && st.state == st_awake);
    c_core_level: cover property (levels_loaded && wr_core);
    c_back_to_back: cover property (reg_wr ##1 reg_rd);
    c_supply_read: cover property (reg_rd && hit(reg_addr, `OFF_SUPPLY_STATUS)
        && st.core_good);
endmodule : power_control_status_regs
`default_nettype wire

// ==== power_control_status_regs_tb.sv ====
// Self-checking testbench of the power control register bank
`timescale 1ns/100ps
`default_nettype none
`include "power_control_defines.svh"

`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module power_control_status_regs_tb;
    import power_control_pkg::*;
    logic clk_sys;
    logic resetn;
    logic [`ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    seq_state_t seq_state;
    logic [3:0] prev_enables;
    logic [2:0] active_mode;
    logic [3:0] active_enables;
    logic [6:0] supply_flags;
    logic [`CORE_LEVEL_W-1:0] strap_core_level;
    logic [`PLL_LEVEL_W-1:0] strap_pll_level;
    logic [1:0] pg_threshold;
    logic err_clear;
    logic [1:0] analog_ilimit;
    logic [1:0] analog_clk_sel;
    logic [1:0] core_ilimit;
    logic [1:0] core_clk_sel;
    logic [`CORE_LEVEL_W-1:0] core_rail_level;
    logic [`PLL_LEVEL_W-1:0] pll_regulator_level;
    logic [10:0] ctl_out;
    int n_errors = 0;
    int n_checks = 0;
    int pos[7] = '{0, 1, 8, 9, 16, 19, 24};

    assign ctl_out = {pg_threshold, err_clear, analog_ilimit, analog_clk_sel, core_ilimit,
                      core_clk_sel};

    power_control_status_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .seq_state(seq_state), .prev_enables(prev_enables), .active_mode(active_mode),
        .active_enables(active_enables), .supply_flags(supply_flags),
        .strap_core_level(strap_core_level), .strap_pll_level(strap_pll_level),
        .pg_threshold(pg_threshold), .err_clear(err_clear), .analog_ilimit(analog_ilimit),
        .analog_clk_sel(analog_clk_sel), .core_ilimit(core_ilimit),
        .core_clk_sel(core_clk_sel), .core_rail_level(core_rail_level),
        .pll_regulator_level(pll_regulator_level));

    // ****************************************
    // Expected words and bus tasks
    // ****************************************
    function automatic logic [31:0] seq_w(input logic [3:0] p, input logic [2:0] s,
                                          input logic [2:0] m, input logic [3:0] e);
        return {2'h0, p[3:2], 2'h0, p[1:0], 5'h0, s, 1'h0, m[2], 4'h0, m[1:0], 2'h0, e[3:2],
                2'h0, e[1:0]};
    endfunction : seq_w

    function automatic logic [31:0] ctrl_w(input logic [1:0] c, input logic clr);
        return {6'h0, c, 7'h0, clr, 1'h0, c, 3'h0, c, 1'h0, c, 3'h0, c};
    endfunction : ctrl_w

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data lives for one cycle only, so it is taken at the edge that closes that cycle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
        `CHK(d, exp)
    endtask : rd_chk

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // Clock, watchdog and scenarios
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        seq_state = st_reset;
        prev_enables = 4'h2;
        active_mode = 3'h0;
        active_enables = 4'h0;
        supply_flags = 7'h00;
        strap_core_level = 7'h2a;
        strap_pll_level = 3'h5;
        repeat (8) @(posedge clk_sys);
        `CHK(ctl_out, {2'h2, 1'h0, 2'h0, 2'h1, 2'h0, 2'h1})
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK({core_rail_level, pll_regulator_level}, {7'h2a, 3'h5})
        rd_chk(`OFF_SEQ_STATUS, 32'h0200_0000);
        rd_chk(`OFF_CONV_CTRL, 32'h0200_0101);
        rd_chk(`OFF_CORE_LEVEL, 32'h0000_002a);
        rd_chk(`OFF_PLL_LEVEL, 32'h0000_0005);
        @(posedge clk_sys);
        `CHK(reg_rdata, 32'h0)
        // Every state code and both values of every mirrored bit
        for (int i = 0; i < 16; i++) begin
            seq_state <= seq_state_t'(i[2:0]);
            prev_enables <= i[3:0];
            active_mode <= i[3:1];
            active_enables <= ~i[3:0];
            rd_chk(`OFF_SEQ_STATUS, seq_w(i[3:0], i[2:0], i[3:1], ~i[3:0]));
        end
        for (int i = 0; i < 7; i++) begin
            supply_flags <= 7'(1 << i);
            rd_chk(`OFF_SUPPLY_STATUS, 32'h1 << pos[i]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_CONV_CTRL, ctrl_w(c[1:0], c[0]));
            @(posedge clk_sys);
            #1 `CHK(ctl_out, {c[1:0], c[0], c[1:0], c[1:0], c[1:0], c[1:0]})
            rd_chk(`OFF_CONV_CTRL, ctrl_w(c[1:0], c[0]));
        end
        // The clear level must hold on its own until software lowers it
        repeat (6) @(posedge clk_sys);
        `CHK(err_clear, 1'b1)
        wr(`OFF_CONV_CTRL, 32'hffff_ffff);
        rd_chk(`OFF_CONV_CTRL, 32'h0301_6363);
        wr(`OFF_CONV_CTRL, 32'hfffe_ffff);
        @(posedge clk_sys);
        #1 `CHK(err_clear, 1'b0)
        // Read-only and unmapped places ignore writes
        wr(`OFF_SEQ_STATUS, 32'hffff_ffff);
        wr(`OFF_SUPPLY_STATUS, 32'hffff_ffff);
        wr(8'h28, 32'h0000_0000);
        rd_chk(`OFF_SUPPLY_STATUS, 32'h0100_0000);
        rd_chk(`OFF_CONV_CTRL, 32'h0300_6363);
        rd_chk(8'h28, 32'h0);
        // One 10 mV code per microsecond, which is 200 cycles at this clock
        for (int v = 8'h2b; v <= 8'h46; v++) begin
            wr(`OFF_CORE_LEVEL, {25'h1ff_ffff, v[6:0]});
            repeat (200) @(posedge clk_sys);
        end
        wr(`OFF_PLL_LEVEL, 32'hffff_fff3);
        @(posedge clk_sys);
        #1 `CHK({core_rail_level, pll_regulator_level}, {7'h46, 3'h3})
        rd_chk(`OFF_CORE_LEVEL, 32'h0000_0046);
        rd_chk(`OFF_PLL_LEVEL, 32'h0000_0003);
        wr(`OFF_PLL_LEVEL, 32'hffff_fff4);
        rd_chk(`OFF_PLL_LEVEL, 32'h0000_0004);
        summarize();
    end
endmodule : power_control_status_regs_tb
`default_nettype wire
